// *** rtl/tsc_alert.v ***
/*
 * Alert output generator for the thermal sensor. Compares the ambient
 * reading with the window and critical limits, applies hysteresis on the
 * falling edge of each condition and drives the alert pin in comparator
 * or latched interrupt behaviour.
 * Assumes limits and reading are 11-bit two's complement, quarter degrees.
 */
`timescale 1ns/1ns
`include "tsc_defines.vh"

module tsc_alert
(
    // Clock and reset
    input  wire                      core_clk_i,
    input  wire                      rstn_i,
    // Settings
    input  wire [1:0]                limit_hysteresis_i,
    input  wire                      alert_en_i,
    input  wire                      alert_sel_i,
    input  wire                      alert_pol_i,
    input  wire                      alert_mode_i,
    input  wire                      int_clear_i,
    // Temperatures
    input  wire [`TSC_TEMP_W-1:0]    ambient_reading_i,
    input  wire [`TSC_TEMP_W-1:0]    high_window_limit_i,
    input  wire [`TSC_TEMP_W-1:0]    low_window_limit_i,
    input  wire [`TSC_TEMP_W-1:0]    critical_limit_i,
    // Alert
    output reg                       alert_active_o,
    output reg                       alert_pin_o
);

    ////////////////////////////////////////////////////////////////////////
    reg  [`TSC_TEMP_W-1:0] hyst_step;
    reg                    over_high;
    reg                    under_low;
    reg                    over_crit;
    reg                    int_latch;
    reg                    cond_q;
    wire signed [`TSC_TEMP_W-1:0] amb  = ambient_reading_i;
    wire signed [`TSC_TEMP_W-1:0] hi   = high_window_limit_i;
    wire signed [`TSC_TEMP_W-1:0] lo   = low_window_limit_i;
    wire signed [`TSC_TEMP_W-1:0] crit = critical_limit_i;
    wire signed [`TSC_TEMP_W-1:0] hs   = hyst_step;
    wire        cond;
    wire        next_active;

    always @*
    begin
        case (limit_hysteresis_i)
            `TSC_HYST_1C5: hyst_step = `TSC_HYST_STEP_1C5;
            `TSC_HYST_3C:  hyst_step = `TSC_HYST_STEP_3C;
            `TSC_HYST_6C:  hyst_step = `TSC_HYST_STEP_6C;
            default:       hyst_step = `TSC_HYST_STEP_0C;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Each condition sets beyond its limit (critical already at it) and only releases once the reading
    // has moved back by the hysteresis, so a slow drift does not chatter.
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            over_high <= 1'b0;
            under_low <= 1'b0;
            over_crit <= 1'b0;
        end
        else
        begin
            over_high <= over_high ? (amb > hi - hs) : (amb > hi); // [R03]
            under_low <= under_low ? (amb < lo + hs) : (amb < lo); // [R03]
            over_crit <= over_crit ? (amb >= crit - hs) : (amb >= crit);
        end
    end

    // Source select zero watches all three limits, one only the critical.
    assign cond = alert_sel_i ? over_crit : (over_high | under_low | over_crit); // [R13]

    // In interrupt behaviour the event latches until the host clears it;
    // a fresh event in the clearing cycle wins.
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            int_latch <= 1'b0;
        else if (cond & ~cond_q)
            int_latch <= 1'b1;
        else if (int_clear_i)
            int_latch <= 1'b0; // [R12]
    end

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            cond_q <= 1'b0;
        else
            cond_q <= cond;
    end

    // Critical crossing in interrupt behaviour still reads as a comparator.
    assign next_active = alert_en_i &
                         (alert_mode_i ? (int_latch | over_crit) : cond); // [R09]

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            alert_active_o <= 1'b0;
            alert_pin_o    <= 1'b1;
        end
        else
        begin
            alert_active_o <= next_active;
            alert_pin_o    <= next_active ~^ alert_pol_i; // [R08]
        end
    end

endmodule

// *** rtl/tsc_defines.vh ***
/*
 * Constants for the thermal sensor settings register: pointer value,
 * field positions, power-up values and field encodings.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

`define TSC_PTR_W            8
`define TSC_PTR_SETTINGS     8'h01
`define TSC_PTR_FEATURE      8'h00
`define TSC_REG_W            16
`define TSC_TEMP_W           11

`define TSC_HYST_HI          10
`define TSC_HYST_LO          9
`define TSC_STOP_BIT         8
`define TSC_CRIT_LOCK_BIT    7
`define TSC_WIN_LOCK_BIT     6
`define TSC_INT_CLEAR_BIT    5
`define TSC_ALERT_STAT_BIT   4
`define TSC_ALERT_EN_BIT     3
`define TSC_ALERT_SEL_BIT    2
`define TSC_ALERT_POL_BIT    1
`define TSC_ALERT_MODE_BIT   0

`define TSC_HYST_RESET       2'h0
`define TSC_HYST_0C          2'h0
`define TSC_HYST_1C5         2'h1
`define TSC_HYST_3C          2'h2
`define TSC_HYST_6C          2'h3
`define TSC_HYST_STEP_1C5    11'h006
`define TSC_HYST_STEP_3C     11'h00c
`define TSC_HYST_STEP_6C     11'h018
`define TSC_HYST_STEP_0C     11'h000

`define TSC_FEATURE_VALUE    16'h0001
`define TSC_ZERO16           16'h0000

`endif

// *** rtl/tsc_settings.v ***
/*
 * Settings register bank of the thermal sensor. The serial bus front end
 * presents a register pointer with write and read strobes; this block
 * holds the settings word, answers reads, guards the limit registers via
 * the lock bits and drives the alert pin through tsc_alert.
 * Assumes the serial front end delivers whole 16-bit words synchronously.
 */
//Function
//[R01] Sixteen-bit settings register at pointer 0x01.
//[R02] Bits 15 to 11 read zero.
//[R03] Bits 10:9 select hysteresis, reset zero.
//[R04] Bit 8 selects shutdown, reset cleared.
//[R05] Shutdown stops conversions; ambient reading holds.
//[R06] Bit 7 locks critical, bit 6 window.
//[R07] Bits 5..0: clear, status, enable, select, polarity, mode.
//[R08] Status read-only; polarity sets alert level.
//[R09] Mode picks comparator or latched interrupt.
//[R10] Shutdown set refused while locked; clear allowed.
//[R11] Locks stick until reset; single write sets.
//[R12] Clear bit clears interrupt, reads zero.
//[R13] Select one: only critical crossing alerts.
//[R14] Hysteresis ignores writes while any lock set.
//[R15] Writes update unlocked fields only, silently.
`timescale 1ns/1ns
`include "tsc_defines.vh"

module tsc_settings
(
    // Clock and reset
    input  wire                      core_clk_i,
    input  wire                      rstn_i,
    // Register port from the serial front end
    input  wire [`TSC_PTR_W-1:0]     reg_ptr_i,
    input  wire                      reg_wr_i,
    input  wire [`TSC_REG_W-1:0]     reg_wdata_i,
    input  wire                      reg_rd_i,
    output reg  [`TSC_REG_W-1:0]     reg_rdata_o,
    // Conversion engine
    input  wire                      conv_done_i,
    input  wire [`TSC_TEMP_W-1:0]    conv_result_i,
    output wire                      conv_run_o,
    output reg  [`TSC_TEMP_W-1:0]    ambient_reading_o,
    // Limit registers held outside this block
    input  wire [`TSC_TEMP_W-1:0]    high_window_limit_i,
    input  wire [`TSC_TEMP_W-1:0]    low_window_limit_i,
    input  wire [`TSC_TEMP_W-1:0]    critical_limit_i,
    output wire                      crit_wr_allow_o,
    output wire                      window_wr_allow_o,
    // Alert pin
    output wire                      alert_pin_o
);

    ////////////////////////////////////////////////////////////////////////
    // Settings state
    reg  [1:0] limit_hysteresis;
    reg        low_power_stop;
    reg        crit_lock;
    reg        win_lock;
    reg        alert_en;
    reg        alert_sel;
    reg        alert_pol;
    reg        alert_mode;
    wire       alert_active;
    wire       any_lock = crit_lock | win_lock;
    wire       wr_cfg   = reg_wr_i & (reg_ptr_i == `TSC_PTR_SETTINGS); // [R01]
    wire       int_clear = wr_cfg & reg_wdata_i[`TSC_INT_CLEAR_BIT]; // [R12]
    wire [`TSC_REG_W-1:0] settings_word;

    ////////////////////////////////////////////////////////////////////////
    // Writes: each field takes the new value only if its lock allows,
    // and refused fields simply hold without any error indication.
    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            limit_hysteresis <= `TSC_HYST_RESET;
            low_power_stop   <= 1'b0;
            crit_lock        <= 1'b0;
            win_lock         <= 1'b0;
            alert_en         <= 1'b0;
            alert_sel        <= 1'b0;
            alert_pol        <= 1'b0;
            alert_mode       <= 1'b0;
        end
        else if (wr_cfg) // [R15]
        begin
            if (!any_lock)
            begin
                limit_hysteresis <= reg_wdata_i[`TSC_HYST_HI:`TSC_HYST_LO]; // [R14]
                alert_en         <= reg_wdata_i[`TSC_ALERT_EN_BIT];
                alert_pol        <= reg_wdata_i[`TSC_ALERT_POL_BIT];
                alert_mode       <= reg_wdata_i[`TSC_ALERT_MODE_BIT];
            end
            if (!win_lock)
                alert_sel <= reg_wdata_i[`TSC_ALERT_SEL_BIT];
            // Leaving shutdown is always allowed; entering it needs both locks clear.
            if (!any_lock || !reg_wdata_i[`TSC_STOP_BIT])
                low_power_stop <= reg_wdata_i[`TSC_STOP_BIT]; // [R10]
            // Locks are set-only: a zero written later cannot release them.
            if (reg_wdata_i[`TSC_CRIT_LOCK_BIT])
                crit_lock <= 1'b1; // [R11]
            if (reg_wdata_i[`TSC_WIN_LOCK_BIT])
                win_lock <= 1'b1; // [R11]
        end
    end

    assign crit_wr_allow_o   = ~crit_lock; // [R06]
    assign window_wr_allow_o = ~win_lock;  // [R06]

    ////////////////////////////////////////////////////////////////////////
    // Conversion: the ambient reading keeps its last good value in shutdown.
    assign conv_run_o = ~low_power_stop; // [R04]

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            ambient_reading_o <= {`TSC_TEMP_W{1'b0}};
        else if (conv_done_i && !low_power_stop)
            ambient_reading_o <= conv_result_i; // [R05]
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.
    assign settings_word = {5'h00,                        // [R02]
                            limit_hysteresis,
                            low_power_stop,
                            crit_lock,
                            win_lock,
                            1'b0,                         // [R12]
                            alert_active,                 // [R08]
                            alert_en,
                            alert_sel,
                            alert_pol,
                            alert_mode};                  // [R07]

    always @(posedge core_clk_i)
    begin
        if (!rstn_i)
            reg_rdata_o <= `TSC_ZERO16;
        else if (reg_rd_i)
        begin
            case (reg_ptr_i)
                `TSC_PTR_SETTINGS: reg_rdata_o <= settings_word;
                `TSC_PTR_FEATURE:  reg_rdata_o <= `TSC_FEATURE_VALUE;
                default:           reg_rdata_o <= `TSC_ZERO16;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    tsc_alert u_alert
    (
        .core_clk_i          (core_clk_i),
        .rstn_i              (rstn_i),
        .limit_hysteresis_i  (limit_hysteresis),
        .alert_en_i          (alert_en),
        .alert_sel_i         (alert_sel),
        .alert_pol_i         (alert_pol),
        .alert_mode_i        (alert_mode),
        .int_clear_i         (int_clear),
        .ambient_reading_i   (ambient_reading_o),
        .high_window_limit_i (high_window_limit_i),
        .low_window_limit_i  (low_window_limit_i),
        .critical_limit_i    (critical_limit_i),
        .alert_active_o      (alert_active),
        .alert_pin_o         (alert_pin_o)
    );

endmodule

// *** sim/tsc_host_model.sv ***
/*
 * Host side of the register port: word writes and reads by pointer.
 * Assumes the bank answers a read one cycle after the read edge.
 */
`timescale 1ns/1ns

module tsc_host_model
(
    // Clock
    input  wire        core_clk_i,
    // Register port
    input  wire [15:0] reg_rdata_i,
    output reg  [7:0]  reg_ptr_o,
    output reg         reg_wr_o,
    output reg  [15:0] reg_wdata_o,
    output reg         reg_rd_o
);
    initial
    begin
        reg_ptr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o = 1'b0;
    end

    // Released write data is inverted so a stale word is never mistaken.
    task wr(input [7:0] ptr, input [15:0] data);
    begin
        @(posedge core_clk_i);
        #1;
        reg_ptr_o = ptr;
        reg_wdata_o = data;
        reg_wr_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~data;
    end
    endtask

    task rd(input [7:0] ptr, output [15:0] data);
    begin
        @(posedge core_clk_i);
        #1;
        reg_ptr_o = ptr;
        reg_rd_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        reg_rd_o = 1'b0;
        data = reg_rdata_i;
    end
    endtask
endmodule

// *** sim/tsc_settings_props.sv ***
/*
 * Port assertions for the settings register bank.
 * Assumes a bind onto tsc_settings with one clock and a low reset.
 */
`timescale 1ns/1ns

module tsc_settings_props
(
    // Clock and reset
    input wire        core_clk_i,
    input wire        rstn_i,
    // Register port
    input wire [7:0]  reg_ptr_i,
    input wire        reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    // Status outputs
    input wire        conv_run_o,
    input wire [10:0] ambient_reading_o,
    input wire        crit_wr_allow_o,
    input wire        window_wr_allow_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    wire settings_wr;
    wire unlocked;
    wire stop_wr;
    wire crit_lock_wr;
    wire win_lock_wr;
    assign settings_wr  = reg_wr_i && (reg_ptr_i == 8'h01);
    assign unlocked     = crit_wr_allow_o && window_wr_allow_o;
    assign stop_wr      = settings_wr && reg_wdata_i[8];
    assign crit_lock_wr = settings_wr && reg_wdata_i[7];
    assign win_lock_wr  = settings_wr && reg_wdata_i[6];

    ////////////////////////////////////////////////////////////////////////
    AST_UPPER_ZERO: assert property (reg_rdata_o[15:11] == 5'h00)
        else $error("upper settings bits read nonzero");
    AST_CLEAR_ZERO: assert property (!reg_rdata_o[5])
        else $error("interrupt clear bit read as one");
    AST_CRIT_LOCK_SET: assert property (crit_lock_wr |=> !crit_wr_allow_o)
        else $error("critical lock not taken");
    AST_WIN_LOCK_SET: assert property (win_lock_wr |=> !window_wr_allow_o)
        else $error("window lock not taken");
    AST_CRIT_LOCK_HOLD: assert property (!crit_wr_allow_o |=> !crit_wr_allow_o)
        else $error("critical lock released");
    AST_WIN_LOCK_HOLD: assert property (!window_wr_allow_o |=> !window_wr_allow_o)
        else $error("window lock released");
    AST_STOP_TAKEN: assert property (stop_wr && unlocked |=> !conv_run_o)
        else $error("shutdown not entered");
    AST_STOP_REFUSED: assert property (stop_wr && !unlocked && conv_run_o |=> conv_run_o)
        else $error("shutdown entered while locked");
    AST_RUN_RESUME: assert property (settings_wr && !reg_wdata_i[8] |=> conv_run_o)
        else $error("continuous conversion not resumed");
    AST_READING_HELD: assert property (!conv_run_o |=> $stable(ambient_reading_o))
        else $error("ambient reading changed in shutdown");
endmodule

bind tsc_settings tsc_settings_props tsc_settings_props_i
(
    .core_clk_i        (core_clk_i),
    .rstn_i            (rstn_i),
    .reg_ptr_i         (reg_ptr_i),
    .reg_wr_i          (reg_wr_i),
    .reg_wdata_i       (reg_wdata_i),
    .reg_rdata_o       (reg_rdata_o),
    .conv_run_o        (conv_run_o),
    .ambient_reading_o (ambient_reading_o),
    .crit_wr_allow_o   (crit_wr_allow_o),
    .window_wr_allow_o (window_wr_allow_o)
);

// *** sim/tsc_settings_tb_top.sv ***
/*
 * Self-checking bench for the settings bank and its alert pin.
 * Assumes tsc_host_model drives the register port.
 */
`timescale 1ns/1ns
`include "tsc_defines.vh"

module tsc_settings_tb_top;
    reg         core_clk_i;
    reg         rstn_i;
    reg         conv_done_i;
    reg  [10:0] conv_result_i;
    reg  [10:0] high_i;
    reg  [10:0] low_i;
    reg  [10:0] crit_i;
    wire [7:0]  ptr;
    wire        wr;
    wire        rd;
    wire [15:0] wdata;
    wire [15:0] rdata;
    wire        run;
    wire [10:0] amb;
    wire        crit_ok;
    wire        win_ok;
    wire        pin;
    integer     failures;
    integer     n_compared;
    reg  [15:0] rv;

    tsc_host_model tsc_host_model_i (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
        .reg_ptr_o(ptr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));
    tsc_settings tsc_settings_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_ptr_i(ptr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .conv_run_o(run),
        .ambient_reading_o(amb), .high_window_limit_i(high_i), .low_window_limit_i(low_i),
        .critical_limit_i(crit_i), .crit_wr_allow_o(crit_ok), .window_wr_allow_o(win_ok),
        .alert_pin_o(pin));

    ////////////////////////////////////////////////////////////////////////
    task check(input [15:0] seen, input [15:0] exp, input string name);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task rdchk(input [15:0] exp);
    begin
        tsc_host_model_i.rd(8'h01, rv);
        check(rv, exp, "settings");
    end
    endtask

    // Five idle cycles let a new reading reach the pin.
    task conv(input [10:0] t);
    begin
        @(posedge core_clk_i);
        #1;
        conv_result_i = t;
        conv_done_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        conv_done_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1;
    end
    endtask

    task results;
    begin
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        #100000;
        failures = failures + 1;
        results;
    end

    initial
    begin
        failures = 0;
        n_compared = 0;
        rstn_i = 1'b0;
        conv_done_i = 1'b0;
        conv_result_i = 11'h000;
        high_i = 11'h0a0;
        low_i = 11'h7c0;
        crit_i = 11'h0c0;
        repeat (6) @(posedge core_clk_i);
        #1;
        rstn_i = 1'b1;
        rdchk(16'h0000);
        tsc_host_model_i.rd(8'h02, rv);
        check(rv, 16'h0000, "unmapped");
        tsc_host_model_i.rd(`TSC_PTR_FEATURE, rv);
        check(rv, `TSC_FEATURE_VALUE, "feature");
        check({15'h0000, run}, 16'h0001, "run");
        check({15'h0000, pin}, 16'h0001, "pin");
        tsc_host_model_i.wr(8'h01, 16'hf73f);
        rdchk(16'h070f);
        conv(11'h064);
        check({5'h00, amb}, 16'h0000, "ambient");
        tsc_host_model_i.wr(8'h01, 16'h0000);
        conv(11'h064);
        check({5'h00, amb}, 16'h0064, "ambient");
        tsc_host_model_i.wr(8'h01, 16'h000e);
        conv(11'h0b0);
        check({15'h0000, pin}, 16'h0000, "pin");
        conv(11'h0d0);
        check({15'h0000, pin}, 16'h0001, "pin");
        rdchk(16'h001e);
        conv(11'h064);
        check({15'h0000, pin}, 16'h0000, "pin");
        // Clear any event latched earlier so the next latch is this scenario's own.
        tsc_host_model_i.wr(8'h01, 16'h002b);
        conv(11'h064);
        check({15'h0000, pin}, 16'h0000, "pin");
        conv(11'h0b0);
        conv(11'h064);
        check({15'h0000, pin}, 16'h0001, "pin");
        tsc_host_model_i.wr(8'h01, 16'h002b);
        repeat (4) @(posedge core_clk_i);
        #1;
        check({15'h0000, pin}, 16'h0000, "pin");
        tsc_host_model_i.wr(8'h01, 16'h010b);
        tsc_host_model_i.wr(8'h01, 16'h014b);
        rdchk(16'h014b);
        check({14'h0000, crit_ok, win_ok}, 16'h0002, "allows");
        tsc_host_model_i.wr(8'h01, 16'h004b);
        check({15'h0000, run}, 16'h0001, "run");
        tsc_host_model_i.wr(8'h01, 16'h0780);
        rdchk(16'h00cb);
        tsc_host_model_i.wr(8'h01, 16'h0000);
        rdchk(16'h00cb);
        @(posedge core_clk_i);
        #1;
        rstn_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        rstn_i = 1'b1;
        rdchk(16'h0000);
        check({14'h0000, crit_ok, win_ok}, 16'h0003, "allows");
        results;
    end
endmodule
